// ---- core/emt_top.sv ----
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module emt_top #(
  parameter int N_OUT = 8
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Encoder and latch pins
  input wire logic ENC_A_I,
  input wire logic ENC_B_I,
  input wire logic ENC_ZERO_I,
  input wire logic LATCH1_I,
  input wire logic LATCH2_I,
  // Distributed system time and output switching events
  input wire logic [63:0] SYS_TIME_I,
  input wire logic [N_OUT-1:0] OUT_SWITCH_I,
  // Interrupt
  output logic IRQ_O
);

  // Slot indices are three bits wide, so more than eight outputs cannot be served.
  if (N_OUT < 1 || N_OUT > 8) begin : g_n_out_check
    $error("N_OUT must lie between 1 and 8");
  end

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  emt_pkg::emt_pins_t pins;
  emt_pkg::emt_pins_t lvl;
  emt_pkg::emt_pins_t rise;
  emt_pkg::emt_pins_t fall;

  assign pins = '{a: ENC_A_I, b: ENC_B_I, zero: ENC_ZERO_I, latch1: LATCH1_I, latch2: LATCH2_I};

  emt_edge #(.WIDTH(5)) u_edge (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .pin_i(pins),
    .level_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic micro_en;
  logic [1:0] eval_mode;
  logic [3:0] n_out;

  assign micro_en = ctrl[emt_pkg::CTRL_MICRO_EN];
  assign eval_mode = ctrl[emt_pkg::CTRL_EVAL_LSB +: 2];
  assign n_out = ctrl[emt_pkg::CTRL_NOUT_LSB +: 4];

  // ---------------------------------------------------------------
  // Counting, period and interpolation
  // ---------------------------------------------------------------
  logic [31:0] count;
  logic [31:0] next_count;
  logic [15:0] period;
  logic [15:0] next_period;
  logic [15:0] since;
  logic [15:0] next_since;
  logic [7:0] sub;
  logic [7:0] next_sub;
  logic overrun;
  logic next_overrun;
  logic cnt_edge;
  logic dir_up;

  function automatic logic count_edge(input logic [1:0] mode, input emt_pkg::emt_pins_t r,
                                      input emt_pkg::emt_pins_t f);
    case (mode)
      emt_pkg::EMT_EVAL_X1: count_edge = r.a;
      emt_pkg::EMT_EVAL_X2: count_edge = r.a | f.a;
      default: count_edge = r.a | f.a | r.b | f.b;
    endcase
  endfunction : count_edge

  // Dividing keeps pace at any speed; a one-step-per-cycle count would lag at high rates.
  function automatic logic [7:0] sub_steps(input logic [15:0] elapsed, input logic [15:0] per);
    logic [31:0] ratio;
    ratio = (32'(elapsed) * emt_pkg::SUB_STEPS) / 32'(per);
    sub_steps = (ratio >= emt_pkg::SUB_STEPS) ? 8'hff : ratio[7:0];
  endfunction : sub_steps

  assign cnt_edge = count_edge(eval_mode, rise, fall);
  // Quadrature direction: A leading B counts upward.
  assign dir_up = (rise.a | fall.a) ? (lvl.a != lvl.b) : (lvl.a == lvl.b);

  always_comb begin
    next_count = count;
    next_period = period;
    next_since = (since == 16'hffff) ? since : since + 16'h0001;
    next_sub = sub;
    next_overrun = overrun;
    if (cnt_edge) begin
      next_count = dir_up ? count + 32'h0000_0001 : count - 32'h0000_0001;
      next_period = next_since;
      next_since = 16'h0000;
      next_sub = 8'h00;
      next_overrun = ({16'h0000, next_period} <= 32'(emt_pkg::MIN_PERIOD_CYC));
    end else if (period != 16'h0000) begin
      next_sub = sub_steps(next_since, period);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count <= 32'h0000_0000;
      period <= 16'h0000;
      since <= 16'hffff;
      sub <= 8'h00;
      overrun <= 1'b0;
    end else begin
      count <= next_count;
      period <= next_period;
      since <= next_since;
      sub <= next_sub;
      overrun <= next_overrun;
    end
  end

  logic [31:0] count_value;
  always_comb begin
    count_value = count;
    if (micro_en) begin
      count_value = {count[23:0], sub};
      if (overrun) begin
        count_value[7:0] = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Captures and timestamps
  // ---------------------------------------------------------------
  logic [31:0] latch1_val;
  logic [31:0] latch2_val;
  logic [63:0] ts_count;
  logic [63:0] ts_zero;
  logic [63:0] ts_l1;
  logic [63:0] ts_l2;
  logic [63:0] ts_out [N_OUT];
  logic zero_hit;
  logic l1_hit;
  logic l2_hit;
  logic [N_OUT-1:0] out_hit;

  assign zero_hit = ctrl[emt_pkg::CTRL_ZERO_EN] & rise.zero;
  assign l1_hit = (ctrl[emt_pkg::CTRL_L1_POS] & rise.latch1) |
                  (ctrl[emt_pkg::CTRL_L1_NEG] & fall.latch1);
  assign l2_hit = (ctrl[emt_pkg::CTRL_L2_POS] & rise.latch2) |
                  (ctrl[emt_pkg::CTRL_L2_NEG] & fall.latch2);

  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      out_hit[i] = OUT_SWITCH_I[i] && (32'(i) < 32'(n_out));
    end
  end

  // Each stamp holds until its next event.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch1_val <= 32'h0000_0000;
      latch2_val <= 32'h0000_0000;
      ts_count <= 64'h0;
      ts_zero <= 64'h0;
      ts_l1 <= 64'h0;
      ts_l2 <= 64'h0;
      for (int i = 0; i < N_OUT; i++) begin
        ts_out[i] <= 64'h0;
      end
    end else begin
      if (cnt_edge) begin
        ts_count <= SYS_TIME_I;
      end
      if (zero_hit | l1_hit) begin
        latch1_val <= count_value;
      end
      if (zero_hit) begin
        ts_zero <= SYS_TIME_I;
      end
      if (l1_hit) begin
        ts_l1 <= SYS_TIME_I;
      end
      if (l2_hit) begin
        latch2_val <= count_value;
        ts_l2 <= SYS_TIME_I;
      end
      for (int i = 0; i < N_OUT; i++) begin
        if (out_hit[i]) begin
          ts_out[i] <= SYS_TIME_I;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [emt_pkg::IRQ_BITS-1:0] irq_stat;
  logic [emt_pkg::IRQ_BITS-1:0] next_irq_stat;
  logic [emt_pkg::IRQ_BITS-1:0] irq_mask;
  logic [emt_pkg::IRQ_BITS-1:0] next_irq_mask;
  logic [emt_pkg::IRQ_BITS-1:0] irq_set;
  logic wr;
  logic rd_ack;
  logic next_ack;

  assign irq_set = {|out_hit, l2_hit, l1_hit, zero_hit, next_overrun & ~overrun};
  assign wr = CYC_I & STB_I & WE_I & ~ACK_O;

  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr && ADR_I == emt_pkg::REG_CTRL) begin
      for (int k = 0; k < 4; k++) begin
        if (SEL_I[k]) begin
          next_ctrl[8*k +: 8] = DAT_I[8*k +: 8];
        end
      end
    end
    if (wr && ADR_I == emt_pkg::REG_IRQ_MASK && SEL_I[0]) begin
      next_irq_mask = DAT_I[emt_pkg::IRQ_BITS-1:0];
    end
    if (wr && ADR_I == emt_pkg::REG_IRQ_STAT && SEL_I[0]) begin
      next_irq_stat = irq_stat & ~DAT_I[emt_pkg::IRQ_BITS-1:0];
    end
    // A new event wins over a clear in the same cycle.
    next_irq_stat = next_irq_stat | irq_set;
    next_ack = CYC_I & STB_I & ~ACK_O;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= emt_pkg::CTRL_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      ACK_O <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      ACK_O <= next_ack;
    end
  end

  assign IRQ_O = |(irq_stat & irq_mask);
  assign rd_ack = next_ack & ~WE_I;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_dat;
  logic ts_on;
  logic ts_wide;
  logic [63:0] ts_pick;

  always_comb begin
    next_dat = 32'h0000_0000;
    ts_pick = 64'h0;
    // Stamps meaningful only in synchronous clock mode.
    // Stamps gated by selected data set.
    ts_on = ctrl[emt_pkg::CTRL_DC_SYNC] &
            (ctrl[emt_pkg::CTRL_TS_SEL] | ctrl[emt_pkg::CTRL_TSC_SEL]);
    ts_wide = ctrl[emt_pkg::CTRL_TS_SEL];
    case (ADR_I)
      emt_pkg::REG_CTRL: next_dat = ctrl;
      emt_pkg::REG_STATUS: next_dat = {30'h0, lvl.zero, overrun};
      emt_pkg::REG_IRQ_STAT: next_dat = {27'h0, irq_stat};
      emt_pkg::REG_IRQ_MASK: next_dat = {27'h0, irq_mask};
      emt_pkg::REG_COUNT: next_dat = count_value;
      emt_pkg::REG_LATCH1: next_dat = latch1_val;
      emt_pkg::REG_LATCH2: next_dat = latch2_val;
      default: next_dat = 32'h0000_0000;
    endcase
    if (ADR_I >= emt_pkg::REG_TS_BASE && ADR_I < emt_pkg::REG_OUT_TS_BASE) begin
      case (ADR_I[4:3])
        2'h0: ts_pick = ts_count;
        2'h1: ts_pick = ts_zero;
        2'h2: ts_pick = ts_l1;
        default: ts_pick = ts_l2;
      endcase
      // High word reads zero in compact form.
      next_dat = !ts_on ? 32'h0 : ADR_I[2] ? (ts_wide ? ts_pick[63:32] : 32'h0) : ts_pick[31:0];
    end
    // The slot window ends where address bit 7 begins; slots past N_OUT read zero.
    if (ADR_I >= emt_pkg::REG_OUT_TS_BASE && !ADR_I[7]) begin
      next_dat = 32'h0000_0000;
      if (ctrl[emt_pkg::CTRL_OTS_SEL] && ctrl[emt_pkg::CTRL_DC_SYNC]
          && 32'(ADR_I[5:3]) < N_OUT && 4'(ADR_I[5:3]) < n_out) begin
        ts_pick = ts_out[ADR_I[5:3]];
        next_dat = ADR_I[2] ? ts_pick[63:32] : ts_pick[31:0];
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DAT_O <= 32'h0000_0000;
    end else if (rd_ack) begin
      DAT_O <= next_dat;
    end
  end

endmodule : emt_top
`default_nettype wire

// ---- common/emt_pkg.sv ----
package emt_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MIN_PERIOD_PS = 1_340_000;
  localparam int unsigned MIN_PERIOD_CYC =
    (MIN_PERIOD_PS + (1_000_000_000 / (CLK_HZ / 1000)) - 1) / (1_000_000_000 / (CLK_HZ / 1000));
  localparam int unsigned SUB_STEPS = 256;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_LATCH1 = 8'h14;
  localparam logic [7:0] REG_LATCH2 = 8'h18;
  localparam logic [7:0] REG_TS_BASE = 8'h20;
  localparam logic [7:0] REG_OUT_TS_BASE = 8'h40;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTRL_MICRO_EN = 0;
  localparam int CTRL_EVAL_LSB = 1;
  localparam int CTRL_ZERO_EN = 3;
  localparam int CTRL_L1_POS = 4;
  localparam int CTRL_L1_NEG = 5;
  localparam int CTRL_L2_POS = 6;
  localparam int CTRL_L2_NEG = 7;
  localparam int CTRL_TS_SEL = 8;
  localparam int CTRL_TSC_SEL = 9;
  localparam int CTRL_OTS_SEL = 10;
  localparam int CTRL_DC_SYNC = 11;
  localparam int CTRL_NOUT_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1000;

  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_ZERO = 1;
  localparam int IRQ_LATCH1 = 2;
  localparam int IRQ_LATCH2 = 3;
  localparam int IRQ_OUTPUT = 4;
  localparam int IRQ_BITS = 5;

  typedef enum logic [1:0] {
    EMT_EVAL_X4 = 2'h0,
    EMT_EVAL_X1 = 2'h1,
    EMT_EVAL_X2 = 2'h2
  } emt_eval_t;

  typedef struct packed {
    logic a;
    logic b;
    logic zero;
    logic latch1;
    logic latch2;
  } emt_pins_t;

endpackage : emt_pkg

// ---- core/emt_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module emt_edge #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Pins
  input wire logic [WIDTH-1:0] pin_i,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  // Edges are taken from the second and third stages, never the first.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;

endmodule : emt_edge
`default_nettype wire

// ---- bench/emt_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module emt_checker (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic rd;

  // ----------------------------------------
  // Control mirror
  // ----------------------------------------
  // Only full-word writes are mirrored; the bench never writes a partial control word.
  always_comb begin
    next_ctrl = ctrl;
    if (CYC_I && STB_I && WE_I && !ACK_O && ADR_I == emt_pkg::REG_CTRL && SEL_I == 4'hf) begin
      next_ctrl = DAT_I;
    end
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= emt_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end
  assign rd = ACK_O && !WE_I;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_ts_rd;
    rd && ADR_I >= emt_pkg::REG_TS_BASE && ADR_I < emt_pkg::REG_OUT_TS_BASE;
  endsequence
  sequence s_out_rd;
    rd && ADR_I[7:6] == 2'h1;
  endsequence

  a_ack_after_req: assert property (s_req |=> ACK_O)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property ($rose(ACK_O) |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  a_ack_needs_req: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("acknowledge without request");
  a_ts_gated_off: assert property (
    s_ts_rd ##0 !(ctrl[11] && (ctrl[8] || ctrl[9])) |-> DAT_O == 32'h0)
    else $error("stamp visible while data set off");
  a_ts_compact_high: assert property (
    s_ts_rd ##0 ADR_I[2] && ctrl[9] && !ctrl[8] |-> DAT_O == 32'h0)
    else $error("compact stamp has a high word");
  a_out_gated_off: assert property (
    s_out_rd ##0 !(ctrl[10] && ctrl[11]) |-> DAT_O == 32'h0)
    else $error("output stamp visible while data set off");
  a_out_slot_range: assert property (
    s_out_rd ##0 {1'b0, ADR_I[5:3]} >= ctrl[15:12] |-> DAT_O == 32'h0)
    else $error("output slot beyond event count");
  a_unmapped_zero: assert property (rd && ADR_I >= 8'h80 |-> DAT_O == 32'h0)
    else $error("unmapped read not zero");
endmodule : emt_checker
bind emt_top emt_checker u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O));
`default_nettype wire

// ---- bench/emt_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module emt_enc_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Step request
  input wire logic go_i,
  input wire logic [15:0] num_i,
  input wire logic [7:0] gap_i,
  // Tracks and busy flag
  output logic a_o,
  output logic b_o,
  output logic busy_o
);
  logic [1:0] st;
  logic [1:0] next_st;
  logic [15:0] rem;
  logic [15:0] next_rem;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  always_comb begin
    next_st = st;
    next_rem = rem;
    next_cnt = cnt + 8'h01;
    if (go_i || rem == 16'h0) begin
      next_rem = go_i ? num_i : rem;
      next_cnt = 8'h00;
    end else if (cnt == gap_i - 8'h01) begin
      next_st = st + 2'h1;
      next_rem = rem - 16'h1;
      next_cnt = 8'h00;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= 2'h0;
      rem <= 16'h0;
      cnt <= 8'h00;
    end else begin
      st <= next_st;
      rem <= next_rem;
      cnt <= next_cnt;
    end
  end
  // Track A leads B by a quarter period, so every step is a forward count.
  assign a_o = st[1] ^ st[0];
  assign b_o = st[1];
  assign busy_o = rem != 16'h0;
endmodule : emt_enc_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] B = 32'h1800;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, a, b, busy;
  logic zero = 1'b0, l1 = 1'b0, l2 = 1'b0, go = 1'b0;
  logic [7:0] adr = 8'h00, osw = 8'h00, gap = 8'h04;
  logic [15:0] num = 16'h0, lf;
  logic [31:0] wdat = 32'h0, dat_o, q;
  logic [63:0] sys = 64'h0, ev, ts, e;
  logic [63:0] ot [8];
  int fail_count = 0, checked = 0, cnt = 0, est = 0, mode, i;

  initial begin
    forever #50 clk = ~clk;
  end
  emt_top #(.N_OUT(8)) dut (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .ENC_A_I(a),
    .ENC_B_I(b), .ENC_ZERO_I(zero), .LATCH1_I(l1), .LATCH2_I(l2), .SYS_TIME_I(sys),
    .OUT_SWITCH_I(osw), .IRQ_O(irq));
  emt_enc_model enc (.clk_i(clk), .rst_i(rst), .go_i(go), .num_i(num), .gap_i(gap),
    .a_o(a), .b_o(b), .busy_o(busy));

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until ack is sampled high at a rising edge, released right after that edge.
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task rd64(input logic [7:0] ad, input logic [63:0] exp);
    logic [31:0] lo;
    wb(1'b0, ad, 32'h0);
    lo = q;
    wb(1'b0, ad + 8'h04, 32'h0);
    chk({q, lo}, exp);
  endtask : rd64
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task rnd_sys;
    @(posedge clk);
    repeat (4) begin
      lf = lfsr_next(lf);
      ev = {ev[47:0], lf};
    end
    sys <= ev;
  endtask : rnd_sys
  // Model counts forward steps by evaluation mode and remembers the last counting edge.
  task start(input int n, input logic [7:0] g);
    int o;
    repeat (n) begin
      o = est;
      est = (est + 1) % 4;
      if (mode == 0 || (mode == 1 && o == 0) || (mode == 2 && o[0] == 1'b0)) begin
        cnt++;
        ts = ev;
      end
    end
    @(posedge clk);
    {go, num, gap} <= {1'b1, 16'(n), g};
    @(posedge clk);
    go <= 1'b0;
  endtask : start
  // The model raises busy only at the edge after go, so one edge passes before it is read.
  task finish;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask : finish
  task pin(input int p, input logic v);
    @(posedge clk);
    if (p == 0) zero <= v;
    else if (p == 1) l1 <= v;
    else l2 <= v;
    repeat (8) @(posedge clk);
  endtask : pin
  task pulse(input int n);
    @(posedge clk);
    osw <= 8'h01 << n;
    @(posedge clk);
    osw <= 8'h00;
    repeat (5) @(negedge clk);
  endtask : pulse
  task give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #3000000;
    fail_count++;
    give_verdict;
  end
  initial begin
    lf = 16'h5318;
    ts = 64'h0;
    mode = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, emt_pkg::REG_CTRL, 32'h0);
    chk(q, emt_pkg::CTRL_RESET);
    wb(1'b0, 8'h80, 32'h0);
    chk(q, 64'h0);
    rd64(emt_pkg::REG_TS_BASE, 64'h0);
    $display("reset test done");
    for (mode = 0; mode < 3; mode++) begin
      wb(1'b1, emt_pkg::REG_CTRL, B | (mode << 1) | (mode == 1 ? 32'h200 : 32'h100));
      for (i = 0; i < 4; i++) begin
        rnd_sys;
        start(1, 8'h04);
        finish;
        rd64(emt_pkg::REG_TS_BASE, mode == 1 ? {32'h0, ts[31:0]} : ts);
      end
    end
    mode = 0;
    $display("count stamp test done");
    for (i = 0; i < 5; i++) begin
      wb(1'b1, emt_pkg::REG_CTRL, B | 32'h100 | (32'h8 << i));
      rnd_sys;
      pin((i + 1) / 2, 1'b1);
      e = ev;
      rnd_sys;
      pin((i + 1) / 2, 1'b0);
      if (i == 2 || i == 4) e = ev;
      rnd_sys;
      rd64(8'h28 + 8'(((i + 1) / 2) * 8), e);
      wb(1'b0, i > 2 ? emt_pkg::REG_LATCH2 : emt_pkg::REG_LATCH1, 32'h0);
      chk(q, cnt);
    end
    $display("latch stamp test done");
    wb(1'b1, emt_pkg::REG_CTRL, 32'h3c00);
    for (i = 0; i < 8; i++) begin
      rnd_sys;
      pulse(i);
      ot[i] = ev;
    end
    for (i = 0; i < 8; i++) rd64(8'h40 + 8'(i * 8), i < 3 ? ot[i] : 64'h0);
    wb(1'b1, emt_pkg::REG_IRQ_STAT, 32'h1f);
    wb(1'b1, emt_pkg::REG_IRQ_MASK, 32'h10);
    @(negedge clk) chk(irq, 1'b0);
    pulse(1);
    chk(irq, 1'b1);
    wb(1'b1, emt_pkg::REG_IRQ_MASK, 32'h0);
    @(negedge clk) chk(irq, 1'b0);
    wb(1'b1, emt_pkg::REG_IRQ_MASK, 32'h10);
    @(negedge clk) chk(irq, 1'b1);
    wb(1'b1, emt_pkg::REG_IRQ_STAT, 32'h10);
    @(negedge clk) chk(irq, 1'b0);
    $display("output stamp test done");
    wb(1'b1, emt_pkg::REG_CTRL, B);
    rd64(emt_pkg::REG_OUT_TS_BASE, 64'h0);
    start(8, 8'd20);
    finish;
    wb(1'b0, emt_pkg::REG_COUNT, 32'h0);
    chk(q, cnt);
    wb(1'b1, emt_pkg::REG_CTRL, B | 32'h1);
    start(12, 8'd40);
    repeat (300) @(posedge clk);
    wb(1'b0, emt_pkg::REG_STATUS, 32'h0);
    chk(q[0], 1'b0);
    finish;
    // A full period has passed since the last step, so the sub-step has saturated.
    repeat (50) @(posedge clk);
    wb(1'b0, emt_pkg::REG_COUNT, 32'h0);
    chk(q[31:8], cnt[23:0]);
    chk(q[7:0], 8'hff);
    start(200, 8'd3);
    repeat (100) @(posedge clk);
    wb(1'b0, emt_pkg::REG_STATUS, 32'h0);
    chk(q[0], 1'b1);
    wb(1'b0, emt_pkg::REG_COUNT, 32'h0);
    chk(q[7:0], 8'h00);
    finish;
    $display("micro step test done");
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
